// ==== verilog/serial_port_baud_generator.sv ====
// serial port baud generator with apb registers and spi/i2c clock pins
//
// Chosen here: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
module serial_port_baud_generator
  import baud_gen_pkg::*;
#(
  parameter int RELOAD_WIDTH = 8
)
(
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // spi master pins
  output logic             spi_sck,
  output logic             spi_sdo,
  input  wire logic        spi_sdi,
  // i2c clock pin, open drain
  input  wire logic        scl_in,
  output logic             scl_out,
  output logic             scl_oe
);

  ////////////////////////////////////////////////////////////////////////
  // address decode

  function automatic logic reg_hit(input logic [7:0] addr);
    reg_hit = (addr == ADDR_RELOAD) || (addr == ADDR_BUFFER) ||
              (addr == ADDR_STATUS) || (addr == ADDR_CONTROL);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // declarations

  logic [RELOAD_WIDTH-1:0] baud_reload_reg;
  logic [RELOAD_WIDTH-1:0] next_baud_reload_reg;
  logic [7:0]              rx_buffer;
  logic [7:0]              next_rx_buffer;
  logic [7:0]              tx_shift;
  logic [7:0]              next_tx_shift;
  logic [7:0]              rx_shift;
  logic [7:0]              next_rx_shift;
  logic                    input_sample_phase;
  logic                    next_input_sample_phase;
  logic                    edge_select;
  logic                    next_edge_select;
  logic                    buffer_full;
  logic                    next_buffer_full;
  logic                    i2c_mode;
  logic                    next_i2c_mode;
  logic                    sck;
  logic                    next_sck;
  logic                    sdo;
  logic                    next_sdo;
  logic [4:0]              halves;
  logic [4:0]              next_halves;
  gen_state_t              state;
  gen_state_t              next_state;
  logic [31:0]             next_prdata;
  logic                    next_pready;
  logic                    next_pslverr;
  logic                    scl_meta;
  logic                    scl_sync;
  logic                    sdi_meta;
  logic                    sdi_sync;
  logic                    load;
  logic                    expired;
  logic                    reload_ok;
  logic                    apb_done;
  logic                    apb_write;
  logic                    apb_read;

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers; only the second stage is read

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      scl_meta <= 1'b1;
      scl_sync <= 1'b1;
      sdi_meta <= 1'b0;
      sdi_sync <= 1'b0;
    end
    else
    begin
      scl_meta <= scl_in;
      scl_sync <= scl_meta;
      sdi_meta <= spi_sdi;
      sdi_sync <= sdi_meta;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // baud counter

  baud_counter #(
    .WIDTH        (RELOAD_WIDTH)
  ) u_counter (
    .pclk         (pclk),
    .presetn      (presetn),
    .load         (load),
    .run          (state == gen_run),
    .reload_value (baud_reload_reg),
    .expired      (expired)
  );

  // i2c holds the reload while another device stretches the released line
  assign reload_ok = ~i2c_mode | ~sck | scl_sync;

  // a transfer completes at the edge where pready is seen high
  assign apb_done  = psel & penable & pready;
  assign apb_write = apb_done & pwrite;
  assign apb_read  = apb_done & ~pwrite;

  ////////////////////////////////////////////////////////////////////////
  // apb answer: one wait state, data and error from flip-flops

  always_comb
  begin
    next_pready  = psel & penable & ~pready;
    next_pslverr = psel & penable & ~pready & ~reg_hit(paddr);
    next_prdata  = prdata;
    if (psel && penable && !pready)
    begin
      next_prdata = 32'h0000_0000;
      case (paddr)
        ADDR_RELOAD:
          next_prdata[RELOAD_WIDTH-1:0] = baud_reload_reg;
        ADDR_BUFFER:
          next_prdata[7:0] = rx_buffer;
        ADDR_STATUS:
        begin
          next_prdata[BIT_SAMPLE_PHASE] = input_sample_phase;
          next_prdata[BIT_EDGE_SELECT]  = edge_select;
          next_prdata[BIT_BUFFER_FULL]  = buffer_full;
        end
        ADDR_CONTROL:
        begin
          next_prdata[BIT_I2C_MODE] = i2c_mode;
          next_prdata[BIT_BUSY]     = (state == gen_run);
        end
        default:
          next_prdata = 32'h0000_0000;
      endcase
    end
  end

  // register the apb answer
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      prdata  <= next_prdata;
      pready  <= next_pready;
      pslverr <= next_pslverr;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // registers and transfer sequencer

  always_comb
  begin
    next_baud_reload_reg    = baud_reload_reg;
    next_rx_buffer          = rx_buffer;
    next_tx_shift           = tx_shift;
    next_rx_shift           = rx_shift;
    next_input_sample_phase = input_sample_phase;
    next_edge_select        = edge_select;
    next_buffer_full        = buffer_full;
    next_i2c_mode           = i2c_mode;
    next_sck                = sck;
    next_sdo                = sdo;
    next_halves             = halves;
    next_state              = state;
    load                    = 1'b0;

    // software writes; reload may change mid transfer, used at next strobe
    if (apb_write)
    begin
      case (paddr)
        ADDR_RELOAD:
          next_baud_reload_reg = pwdata[RELOAD_WIDTH-1:0];
        ADDR_STATUS:
        begin
          next_input_sample_phase = pwdata[BIT_SAMPLE_PHASE];
          next_edge_select        = pwdata[BIT_EDGE_SELECT];
        end
        ADDR_CONTROL:
          if (state == gen_idle)
          begin
            next_i2c_mode = pwdata[BIT_I2C_MODE];
            next_sck      = pwdata[BIT_I2C_MODE];
          end
        default:
          next_i2c_mode = i2c_mode;
      endcase
    end

    // reading the buffer empties it
    if (apb_read && (paddr == ADDR_BUFFER))
      next_buffer_full = 1'b0;

    case (state)
      gen_idle:
      begin
        // writes during a transfer are dropped rather than corrupt it
        if (apb_write && (paddr == ADDR_BUFFER))
        begin
          load          = 1'b1;
          next_state    = gen_run;
          next_tx_shift = pwdata[7:0];
          next_sdo      = pwdata[7];
          next_halves   = 5'h00;
          next_sck      = i2c_mode;
        end
      end
      gen_run:
      begin
        if (expired && reload_ok)
        begin
          next_sck    = ~sck;
          next_halves = halves + 5'h01;
          if (!i2c_mode && !sck && !input_sample_phase)
            next_rx_shift = {rx_shift[6:0], sdi_sync};
          if (!i2c_mode && sck)
          begin
            if (input_sample_phase)
              next_rx_shift = {rx_shift[6:0], sdi_sync};
            next_tx_shift = {tx_shift[6:0], 1'b0};
            next_sdo      = tx_shift[6];
          end
          if (halves == HALVES_PER_BYTE - 5'h01)
          begin
            // no reload: counter halts, sck keeps its last level
            next_state       = gen_idle;
            next_rx_buffer   = next_rx_shift;
            next_buffer_full = 1'b1;
          end
          else
            load = 1'b1;
        end
      end
      default:
        next_state = gen_idle;
    endcase
  end

  // register the sequencer state
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      baud_reload_reg    <= RESET_RELOAD[RELOAD_WIDTH-1:0];
      rx_buffer          <= RESET_BUFFER;
      tx_shift           <= RESET_BUFFER;
      rx_shift           <= RESET_BUFFER;
      input_sample_phase <= RESET_STATUS[BIT_SAMPLE_PHASE];
      edge_select        <= RESET_STATUS[BIT_EDGE_SELECT];
      buffer_full        <= RESET_STATUS[BIT_BUFFER_FULL];
      i2c_mode           <= RESET_I2C;
      sck                <= RESET_I2C;
      sdo                <= 1'b0;
      halves             <= 5'h00;
      state              <= gen_idle;
    end
    else
    begin
      baud_reload_reg    <= next_baud_reload_reg;
      rx_buffer          <= next_rx_buffer;
      tx_shift           <= next_tx_shift;
      rx_shift           <= next_rx_shift;
      input_sample_phase <= next_input_sample_phase;
      edge_select        <= next_edge_select;
      buffer_full        <= next_buffer_full;
      i2c_mode           <= next_i2c_mode;
      sck                <= next_sck;
      sdo                <= next_sdo;
      halves             <= next_halves;
      state              <= next_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pin drivers, registered from the next values so they match sck

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      spi_sck <= 1'b0;
      spi_sdo <= 1'b0;
      scl_out <= 1'b0;
      scl_oe  <= 1'b0;
    end
    else
    begin
      spi_sck <= ~next_i2c_mode & next_sck;
      spi_sdo <= ~next_i2c_mode & next_sdo;
      scl_out <= 1'b0;
      scl_oe  <= next_i2c_mode & ~next_sck;
    end
  end

endmodule

// ==== pkg/baud_gen_pkg.sv ====
// constants and types shared by the serial port baud generator
package baud_gen_pkg;

  // register byte addresses on the apb bus
  localparam logic [7:0] ADDR_RELOAD  = 8'h00;
  localparam logic [7:0] ADDR_BUFFER  = 8'h04;
  localparam logic [7:0] ADDR_STATUS  = 8'h08;
  localparam logic [7:0] ADDR_CONTROL = 8'h0c;

  // field positions in serial_status_reg
  localparam int BIT_SAMPLE_PHASE = 7;
  localparam int BIT_EDGE_SELECT  = 6;
  localparam int BIT_BUFFER_FULL  = 0;

  // field positions in the control register
  localparam int BIT_I2C_MODE = 0;
  localparam int BIT_BUSY     = 7;

  // values after reset
  localparam logic [7:0] RESET_RELOAD  = 8'h00;
  localparam logic [7:0] RESET_STATUS  = 8'h00;
  localparam logic [7:0] RESET_BUFFER  = 8'h00;
  localparam logic       RESET_I2C     = 1'b0;

  // half periods of the serial clock in one byte transfer
  localparam logic [4:0] HALVES_PER_BYTE = 5'h10;

  // generator sequencing
  typedef enum {gen_idle, gen_run} gen_state_t;

endpackage

// ==== verilog/baud_counter.sv ====
// baud counter: loads the reload value and counts down at half pclk rate
`timescale 1ns/1ps
module baud_counter
  import baud_gen_pkg::*;
#(
  parameter int WIDTH = 8
)
(
  // clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  // control from the sequencer
  input  wire logic             load,
  input  wire logic             run,
  input  wire logic [WIDTH-1:0] reload_value,
  // terminal count, high on every second pclk while waiting at zero
  output logic                  expired
);

  logic [WIDTH-1:0] count;
  logic [WIDTH-1:0] next_count;
  logic             tick;
  logic             next_tick;

  // zero reached on the decrement slot ends one half period
  assign expired = run & tick & (count == '0);

  // next count: load wins, else decrement every second pclk
  always_comb
  begin
    next_count = count;
    next_tick  = 1'b0;
    if (load)
    begin
      next_count = reload_value;
      next_tick  = 1'b0;
    end
    else if (run)
    begin
      next_tick = ~tick;
      if (tick && (count != '0))
        next_count = count - 1'b1;
    end
  end

  // register the counter state
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      count <= '0;
      tick  <= 1'b0;
    end
    else
    begin
      count <= next_count;
      tick  <= next_tick;
    end
  end

endmodule

// ==== dv/serial_far_side.sv ====
// far side model: spi slave returning a byte and i2c clock stretcher
`timescale 1ns/1ps
module serial_far_side
(
  // spi pins
  input  wire logic       spi_sck,
  output logic            spi_sdi,
  // byte to return and stretch request from the bench
  input  wire logic [7:0] tx_byte,
  input  wire logic       load,
  input  wire logic       stretch,
  // i2c clock wire
  input  wire logic       scl_out,
  input  wire logic       scl_oe,
  output logic            scl_in
);
  logic [7:0] sr;
  // rotates on every rising sck, so a late sampler sees the next bit
  always @(posedge spi_sck or posedge load)
    if (load)
      sr <= tx_byte;
    else
      sr <= {sr[6:0], sr[7]};
  assign spi_sdi = sr[7];
  // wired-and line with pull-up; the slave may hold it low
  assign scl_in = (scl_oe ? scl_out : 1'b1) && !stretch;
endmodule

// ==== dv/serial_port_baud_generator_properties.sv ====
// assertion checker for the serial port baud generator ports
`timescale 1ns/1ps
module baud_gen_properties
  import baud_gen_pkg::*;
(
  // watched ports
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        spi_sck,
  input wire logic        spi_sdo,
  input wire logic        scl_out,
  input wire logic        scl_oe
);
  logic [7:0] rel;
  logic       i2c, i2c_d1, i2c_d2, active, clk_d;
  logic [4:0] togs;
  logic [9:0] cnt;
  logic       wr, start, clk_obs, chg, steady;
  logic [8:0] half_m1;
  assign wr      = psel && penable && pready && pwrite && !pslverr;
  assign start   = wr && paddr == ADDR_BUFFER && !active;
  assign clk_obs = i2c ? !scl_oe : spi_sck;
  assign chg     = clk_obs != clk_d;
  assign half_m1 = {rel, 1'b1};
  assign steady  = i2c == i2c_d1 && i2c_d1 == i2c_d2;
  // shadow of reload and mode; control writes while busy are dropped
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      {rel, i2c, i2c_d1, i2c_d2, active, clk_d} <= '0;
      togs <= '0;
      cnt  <= '0;
    end
    else
    begin
      if (wr && paddr == ADDR_RELOAD && !active)
        rel <= pwdata[7:0];
      if (wr && paddr == ADDR_CONTROL && !active)
        i2c <= pwdata[BIT_I2C_MODE];
      i2c_d1 <= i2c;
      i2c_d2 <= i2c_d1;
      clk_d  <= clk_obs;
      cnt    <= (start || chg) ? '0 : cnt + {9'h0, cnt != 10'h3ff};
      togs   <= start ? '0 : togs + {4'h0, active && chg};
      active <= start || (active && !(chg && togs == 5'h0f));
    end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_half_exact: assert property (
    !i2c && active && togs != 0 && chg |-> cnt == {1'b0, half_m1})
    else $error("spi clock half period wrong");
  a_first_edge: assert property (
    !i2c && active && togs == 0 |-> cnt <= {1'b0, half_m1} + 10'd3)
    else $error("transfer did not start after buffer write");
  a_stop_hold: assert property (
    steady && !active && !start |-> !chg)
    else $error("serial clock moved while idle");
  a_spi_idle_low: assert property (
    !i2c && steady && !active |-> !spi_sck)
    else $error("spi clock not idle low");
  a_i2c_released: assert property (
    i2c && steady && !active |-> !scl_oe && !scl_out)
    else $error("i2c clock not released when idle");
  a_i2c_spi_quiet: assert property (
    i2c && steady |-> !spi_sck && !spi_sdo)
    else $error("spi pins active in i2c mode");
  // bound follows the reload, so slow but legal settings do not trip it
  a_no_hang: assert property (
    active |-> cnt < {1'b0, half_m1} + 10'd64)
    else $error("transfer stalled");
  a_apb_one_wait: assert property (
    psel && penable && !pready |=> pready)
    else $error("apb answer late");
  a_apb_one_pulse: assert property (
    pready |=> !pready)
    else $error("apb ready held too long");
  a_err_unmapped: assert property (
    pready |-> pslverr == (paddr[1:0] != 0 || paddr > ADDR_CONTROL))
    else $error("slave error flag wrong");
endmodule
bind serial_port_baud_generator baud_gen_properties u_baud_gen_properties (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .pslverr(pslverr), .spi_sck(spi_sck), .spi_sdo(spi_sdo),
  .scl_out(scl_out), .scl_oe(scl_oe));

// ==== dv/serial_port_baud_generator_tb_top.sv ====
// self-checking testbench for the serial port baud generator
`timescale 1ns/1ps
module serial_port_baud_generator_tb_top;
  import baud_gen_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr, tx_byte, sdo_byte;
  logic [31:0] pwdata, prdata;
  logic        spi_sck, spi_sdo, spi_sdi, scl_in, scl_out, scl_oe;
  logic        load, stretch;
  logic [32:0] expq[$];
  logic [32:0] e;
  int          fail_count, samples_checked;
  serial_port_baud_generator u_serial_port_baud_generator (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .spi_sck(spi_sck),
    .spi_sdo(spi_sdo), .spi_sdi(spi_sdi), .scl_in(scl_in),
    .scl_out(scl_out), .scl_oe(scl_oe));
  serial_far_side u_serial_far_side (
    .spi_sck(spi_sck), .spi_sdi(spi_sdi), .tx_byte(tx_byte), .load(load),
    .stretch(stretch), .scl_out(scl_out), .scl_oe(scl_oe), .scl_in(scl_in));
  always #50 pclk = ~pclk;
  ////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] seen, exp);
    samples_checked++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic test_done;
    $display("checks %0d errors %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // one apb transfer; an idle edge follows so no signal is set twice
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, input logic [31:0] exp);
    int n;
    expq.push_back({a[1:0] != 0 || a > ADDR_CONTROL, exp});
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1)
    begin
      fail_count++;
      test_done;
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // counts 16 clock toggles, collecting sdo at each rising sck
  task automatic wait_toggles(input logic i2c, output int cyc);
    int   t;
    logic last;
    t = 0;
    cyc = 0;
    last = i2c ? scl_oe : spi_sck;
    while (t < 16 && cyc < 5000)
    begin
      @(posedge pclk);
      cyc++;
      if ((i2c ? scl_oe : spi_sck) !== last)
      begin
        t++;
        last = ~last;
        if (!i2c && last)
          sdo_byte = {sdo_byte[6:0], spi_sdo};
      end
    end
    if (t < 16)
    begin
      fail_count++;
      test_done;
    end
  endtask
  ////////////////////////////////////////////////////////////////////////
  // read results are matched against the oldest note in order
  always @(posedge pclk)
    if (psel && penable && pready === 1'b1)
    begin
      e = expq.pop_front();
      check("pslverr", {31'h0, pslverr}, {31'h0, e[32]});
      if (!pwrite)
        check("prdata", prdata, e[31:0]);
    end
  // main sequence: reset values, spi in both phases, i2c with stretch
  initial
  begin
    logic [7:0] d, r;
    int         cyc;
    {pclk, presetn, psel, penable, pwrite, load, stretch} = '0;
    {paddr, tx_byte, sdo_byte, pwdata} = '0;
    void'($urandom(69236));
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(0, ADDR_RELOAD, 0, {24'h0, RESET_RELOAD});
    apb(0, ADDR_STATUS, 0, {24'h0, RESET_STATUS});
    apb(0, ADDR_CONTROL, 0, 32'h0);
    apb(0, 8'h10, 0, 32'h0);
    apb(1, 8'h12, 32'hff, 0);
    for (int i = 0; i < 4; i++)
    begin
      r = (i == 0) ? 8'h03 : 8'(3 + $urandom % 4);
      d = 8'($urandom);
      tx_byte <= d;
      @(posedge pclk);
      load <= 1'b1;
      @(posedge pclk);
      load <= 1'b0;
      apb(1, ADDR_RELOAD, {24'h0, r}, 0);
      apb(1, ADDR_STATUS, {24'h0, i[0], i[1], 6'h0}, 0);
      apb(1, ADDR_BUFFER, {24'h0, d ^ 8'h5a}, 0);
      apb(1, ADDR_BUFFER, 32'h0, 0); // dropped while busy
      wait_toggles(0, cyc);
      check("sdo byte", sdo_byte, d ^ 8'h5a);
      check("byte time", cyc >= 32 * (r + 1) - 8 && cyc <= 32 * (r + 1),
            1);
      apb(0, ADDR_CONTROL, 0, 32'h0);
      apb(0, ADDR_STATUS, 0, {24'h0, i[0], i[1], 6'h1});
      apb(0, ADDR_BUFFER, 0, i[0] ? {d[6:0], d[7]} : d);
      apb(0, ADDR_STATUS, 0, {24'h0, i[0], i[1], 6'h0});
    end
    apb(1, ADDR_CONTROL, 32'h1, 0);
    apb(1, ADDR_RELOAD, 32'h3, 0);
    apb(1, ADDR_BUFFER, 32'ha5, 0);
    fork
      wait_toggles(1, cyc);
      begin
        repeat (40) @(posedge pclk);
        stretch <= 1'b1;
        repeat (20) @(posedge pclk);
        stretch <= 1'b0;
      end
    join
    // the held-low line delays one released half by one full half period
    check("i2c stretch", cyc >= 32 * 4 + 8 && cyc <= 32 * 4 + 16,
          1);
    apb(0, ADDR_CONTROL, 0, 32'h1);
    test_done;
  end
endmodule
